/* verilog/acr_config_regs.sv */
/*
  Configuration register bank for a delta-sigma converter: the gain and
  bypass register and the rate/mode register, plus the decoded controls
  that steer the converter core.
  Assumes an Avalon-MM master on clk, word accesses, synchronous reset.
*/
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module acr_config_regs (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [3:0] input_select,
  output logic [7:0] input_amplifier_gain,
  output logic amp_bypass,
  output logic [11:0] rate_sps,
  output logic rate_reserved,
  output logic [11:0] mod_clk_khz,
  output logic conversion_repeat_select,
  output logic [1:0] ref_select,
  output logic temp_sense_enable
);
  // ***********************************************
  // bus handshake
  // ***********************************************
  // one wait state: a request is acknowledged in its second cycle,
  // which keeps the read data registered
  logic ack;
  wire req = (avs_read | avs_write) & ~ack;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ack <= 1'b0;
    end else begin
      ack <= req;
    end
  end

  // ***********************************************
  // registers
  // ***********************************************
  logic [7:0] input_gain_config;
  logic [7:0] converter_rate_mode_config;
  // writes land on the acknowledge edge, where the master sees it
  wire wr_take = avs_write & ack & avs_byteenable[0];
  wire wr_gain = wr_take & (avs_address == acr_pkg::ADDR_GAIN_CFG);
  wire wr_rate = wr_take & (avs_address == acr_pkg::ADDR_RATE_CFG);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      input_gain_config <= acr_pkg::RESET_VALUE;
      converter_rate_mode_config <= acr_pkg::RESET_VALUE;
    end else begin
      if (wr_gain) begin
        input_gain_config <= avs_writedata[7:0];
      end
      if (wr_rate) begin
        converter_rate_mode_config <= avs_writedata[7:0];
      end
    end
  end

  // ***********************************************
  // field decode
  // ***********************************************
  function automatic logic [11:0] acr_rate_normal(input logic [2:0] code);
    acr_rate_normal = acr_pkg::RATE_NORMAL_SPS[code];
  endfunction

  // reserved rate code, used by the output flag and the status word
  function automatic logic acr_rate_is_reserved(input logic [2:0] code);
    acr_rate_is_reserved = (code == acr_pkg::RATE_RESERVED);
  endfunction

  wire [2:0] gain_code =
    input_gain_config[acr_pkg::GAIN_MSB:acr_pkg::GAIN_LSB];
  wire bypass_bit = input_gain_config[acr_pkg::BYPASS_BIT];
  wire [2:0] rate_code =
    converter_rate_mode_config[acr_pkg::RATE_MSB:acr_pkg::RATE_LSB];
  wire turbo = converter_rate_mode_config[acr_pkg::TURBO_BIT];
  wire repeat_bit = converter_rate_mode_config[acr_pkg::REPEAT_BIT];
  wire [1:0] ref_code =
    converter_rate_mode_config[acr_pkg::REF_MSB:acr_pkg::REF_LSB];
  wire temp_bit = converter_rate_mode_config[acr_pkg::TEMP_BIT];

  // temperature mode discards the whole gain register
  wire [2:0] eff_gain_code = temp_bit ? 3'h0 : gain_code;
  wire eff_bypass = ~temp_bit & bypass_bit &
    (eff_gain_code < acr_pkg::GAIN_CODE_8);
  wire [7:0] next_gain = acr_pkg::GAIN_UNITY << eff_gain_code;
  wire [11:0] normal_sps = acr_rate_normal(rate_code);
  wire [11:0] next_sps = turbo ? {normal_sps[10:0], 1'b0} : normal_sps;
  wire [11:0] next_mod = turbo ? acr_pkg::MOD_CLK_TURBO_KHZ
                               : acr_pkg::MOD_CLK_NORMAL_KHZ;
  acr_pkg::acr_ref_t next_ref;
  assign next_ref = temp_bit ? acr_pkg::ACR_REF_INTERNAL :
    (ref_code == acr_pkg::REF_CODE_INTERNAL) ? acr_pkg::ACR_REF_INTERNAL :
    (ref_code == acr_pkg::REF_CODE_EXTERNAL) ? acr_pkg::ACR_REF_EXTERNAL :
    acr_pkg::ACR_REF_SUPPLY;
  wire [3:0] next_input = temp_bit ? 4'h0
    : input_gain_config[acr_pkg::MUX_MSB:acr_pkg::MUX_LSB];

  // ***********************************************
  // core controls and read data, registered
  // ***********************************************
  wire reserved_now = acr_rate_is_reserved(rate_code);
  wire [31:0] status_word = {20'h00000, eff_bypass, next_ref, reserved_now,
    next_gain};
  wire [31:0] next_readdata =
    (avs_address == acr_pkg::ADDR_GAIN_CFG) ?
      {24'h000000, input_gain_config} :
    (avs_address == acr_pkg::ADDR_RATE_CFG) ?
      {24'h000000, converter_rate_mode_config} :
    (avs_address == acr_pkg::ADDR_STATUS) ? status_word :
    acr_pkg::UNMAPPED_READ;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      avs_readdata <= 32'h00000000;
      input_select <= 4'h0;
      input_amplifier_gain <= acr_pkg::GAIN_UNITY;
      amp_bypass <= 1'b0;
      rate_sps <= acr_pkg::RATE_NORMAL_SPS[0];
      rate_reserved <= 1'b0;
      mod_clk_khz <= acr_pkg::MOD_CLK_NORMAL_KHZ;
      conversion_repeat_select <= 1'b0;
      ref_select <= 2'h0;
      temp_sense_enable <= 1'b0;
    end else begin
      avs_readdata <= (avs_read & req) ? next_readdata : avs_readdata;
      input_select <= next_input;
      input_amplifier_gain <= next_gain;
      amp_bypass <= eff_bypass;
      rate_sps <= next_sps;
      rate_reserved <= reserved_now;
      mod_clk_khz <= next_mod;
      conversion_repeat_select <= repeat_bit;
      ref_select <= next_ref;
      temp_sense_enable <= temp_bit;
    end
  end

  // ***********************************************
  // checks
  // ***********************************************
  sequence seq_write_rate;
    wr_rate;
  endsequence

  AST_BYPASS_HIGH_GAIN: assert property (@(posedge clk) disable iff (!reset_n)
    (gain_code >= acr_pkg::GAIN_CODE_8) |=> !amp_bypass)
    else $error("bypass active at gain eight or above");
  AST_BYPASS_LOW_GAIN: assert property (@(posedge clk) disable iff (!reset_n)
    (bypass_bit && !temp_bit && gain_code < acr_pkg::GAIN_CODE_8)
      |=> amp_bypass)
    else $error("bypass not honoured at low gain");
  AST_GAIN_MAP: assert property (@(posedge clk) disable iff (!reset_n)
    !temp_bit |=> input_amplifier_gain == (8'h01 << $past(gain_code)))
    else $error("gain mapping wrong");
  AST_TURBO_DOUBLE: assert property (@(posedge clk) disable iff (!reset_n)
    (turbo && rate_code == 3'h6) |=> rate_sps == 12'h7D0)
    else $error("turbo top rate wrong");
  AST_RATE_DEFAULT: assert property (@(posedge clk) disable iff (!reset_n)
    (!turbo && rate_code == 3'h0) |=> rate_sps == 12'h014)
    else $error("default rate wrong");
  AST_MOD_CLK: assert property (@(posedge clk) disable iff (!reset_n)
    turbo |=> mod_clk_khz == acr_pkg::MOD_CLK_TURBO_KHZ)
    else $error("modulator clock not turbo");
  AST_REPEAT: assert property (@(posedge clk) disable iff (!reset_n)
    seq_write_rate |=> ##1 conversion_repeat_select
      == $past(avs_writedata[3], 2))
    else $error("conversion repeat not following write");
  AST_REF_SUPPLY: assert property (@(posedge clk) disable iff (!reset_n)
    (!temp_bit && ref_code[1])
      |=> ref_select == acr_pkg::ACR_REF_SUPPLY)
    else $error("supply reference not chosen");
  AST_TEMP_REF: assert property (@(posedge clk) disable iff (!reset_n)
    temp_bit |=> (ref_select == acr_pkg::ACR_REF_INTERNAL)
      && input_amplifier_gain == 8'h01 && !amp_bypass)
    else $error("temperature mode not forcing internal settings");
  AST_RATE_ADDR: assert property (@(posedge clk) disable iff (!reset_n)
    seq_write_rate |=> converter_rate_mode_config
      == $past(avs_writedata[7:0]))
    else $error("rate register write lost");

  // ***********************************************
  // bus handshake checks
  // ***********************************************
  // a first-cycle request, and the edges that complete a transfer
  sequence seq_fresh_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence

  sequence seq_read_done;
    avs_read && !avs_waitrequest;
  endsequence

  sequence seq_write_done;
    avs_write && !avs_waitrequest && avs_byteenable[0];
  endsequence

  sequence seq_lane_off_write;
    avs_write && !avs_waitrequest && !avs_byteenable[0];
  endsequence

  AST_IDLE_NO_WAIT: assert property (
    @(posedge clk) disable iff (!reset_n)
    !(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest raised with no request");

  AST_ONE_WAIT: assert property (
    @(posedge clk) disable iff (!reset_n)
    seq_fresh_req |=> !avs_waitrequest)
    else $error("request held for more than one wait state");

  // a slow master may still be latching read data one edge later
  AST_READ_HOLD: assert property (
    @(posedge clk) disable iff (!reset_n)
    seq_read_done |=> $stable(avs_readdata))
    else $error("read data changed after the answer");

  AST_GAIN_WRITE: assert property (
    @(posedge clk) disable iff (!reset_n)
    seq_write_done ##0 (avs_address == acr_pkg::ADDR_GAIN_CFG)
      |=> input_gain_config == $past(avs_writedata[7:0]))
    else $error("gain register write lost");

  // refused writes must leave both registers as they were
  AST_REFUSED_LANE: assert property (
    @(posedge clk) disable iff (!reset_n)
    seq_lane_off_write
      |=> $stable(input_gain_config) && $stable(converter_rate_mode_config))
    else $error("write with lane 0 off changed a register");

  AST_REFUSED_ADDR: assert property (
    @(posedge clk) disable iff (!reset_n)
    seq_write_done ##0 (avs_address != acr_pkg::ADDR_GAIN_CFG)
      ##0 (avs_address != acr_pkg::ADDR_RATE_CFG)
      |=> $stable(input_gain_config) && $stable(converter_rate_mode_config))
    else $error("write to an unmapped address changed a register");

  // ***********************************************
  // status word checks
  // ***********************************************
  // status word and core outputs load on one edge from one decode
  sequence seq_status_read;
    avs_read && avs_waitrequest && (avs_address == acr_pkg::ADDR_STATUS);
  endsequence

  AST_STATUS_GAIN: assert property (
    @(posedge clk) disable iff (!reset_n)
    seq_status_read |=> avs_readdata[7:0] == input_amplifier_gain)
    else $error("status gain differs from the amplifier output");

  AST_STATUS_FLAGS: assert property (
    @(posedge clk) disable iff (!reset_n)
    seq_status_read
      |=> avs_readdata[11:8] == {amp_bypass, ref_select, rate_reserved})
    else $error("status flags differ from the core outputs");

  AST_STATUS_UPPER: assert property (
    @(posedge clk) disable iff (!reset_n)
    seq_status_read |=> avs_readdata[31:12] == 20'h00000)
    else $error("status upper bits not zero");

  // ***********************************************
  // decoded control checks
  // ***********************************************
  // one pair per defined code, against the tables rather than the shift
  for (genvar k = 0; k < int'(acr_pkg::RATE_RESERVED); k++) begin : g_rate
    AST_RATE_NORMAL: assert property (
      @(posedge clk) disable iff (!reset_n)
      (!turbo && rate_code == k)
        |=> rate_sps == acr_pkg::RATE_NORMAL_SPS[k])
      else $error("normal mode rate wrong");

    AST_RATE_TURBO: assert property (
      @(posedge clk) disable iff (!reset_n)
      (turbo && rate_code == k)
        |=> rate_sps == acr_pkg::RATE_TURBO_SPS[k])
      else $error("turbo mode rate wrong");
  end

  AST_RATE_RESERVED: assert property (
    @(posedge clk) disable iff (!reset_n)
    (rate_code == acr_pkg::RATE_RESERVED)
      |=> rate_reserved && rate_sps == 12'h000)
    else $error("reserved rate code not flagged");

  AST_MOD_CLK_NORMAL: assert property (
    @(posedge clk) disable iff (!reset_n)
    !turbo |=> mod_clk_khz == acr_pkg::MOD_CLK_NORMAL_KHZ)
    else $error("modulator clock not normal");

  AST_REPEAT_SINGLE: assert property (
    @(posedge clk) disable iff (!reset_n)
    !repeat_bit |=> !conversion_repeat_select)
    else $error("continuous mode without its bit");

  AST_REF_INTERNAL: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!temp_bit && ref_code == acr_pkg::REF_CODE_INTERNAL)
      |=> ref_select == acr_pkg::ACR_REF_INTERNAL)
    else $error("internal reference not chosen");

  AST_REF_EXTERNAL: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!temp_bit && ref_code == acr_pkg::REF_CODE_EXTERNAL)
      |=> ref_select == acr_pkg::ACR_REF_EXTERNAL)
    else $error("external reference not chosen");

  // temperature mode hides the whole gain register from the core
  AST_TEMP_INPUT: assert property (
    @(posedge clk) disable iff (!reset_n)
    temp_bit |=> input_select == 4'h0)
    else $error("input selection not cleared in temperature mode");

  AST_TEMP_LEVEL: assert property (
    @(posedge clk) disable iff (!reset_n)
    temp_bit |=> temp_sense_enable)
    else $error("temperature mode not enabled");

  AST_INPUT_SELECT: assert property (
    @(posedge clk) disable iff (!reset_n)
    !temp_bit |=> input_select
      == $past(input_gain_config[acr_pkg::MUX_MSB:acr_pkg::MUX_LSB]))
    else $error("input selection not following the register");

  AST_BYPASS_OFF: assert property (
    @(posedge clk) disable iff (!reset_n)
    !bypass_bit |=> !amp_bypass)
    else $error("bypass active without its bit");
endmodule
`default_nettype wire

/* verilog/acr_pkg.sv */
/*
  Constants for the converter configuration register bank: register
  offsets, field positions, reset values and rate tables.
  Assumes a 20 MHz system clock and a byte-addressed Avalon-MM slave.
*/
`default_nettype none
package acr_pkg;
  // ***********************************************
  // register map (byte addresses)
  // ***********************************************
  localparam logic [3:0] ADDR_GAIN_CFG = 4'h0;
  localparam logic [3:0] ADDR_RATE_CFG = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

  // ***********************************************
  // field positions
  // ***********************************************
  localparam int BYPASS_BIT = 0;
  localparam int GAIN_LSB = 1;
  localparam int GAIN_MSB = 3;
  localparam int MUX_LSB = 4;
  localparam int MUX_MSB = 7;
  localparam int TEMP_BIT = 0;
  localparam int REF_LSB = 1;
  localparam int REF_MSB = 2;
  localparam int REPEAT_BIT = 3;
  localparam int TURBO_BIT = 4;
  localparam int RATE_LSB = 5;
  localparam int RATE_MSB = 7;

  // ***********************************************
  // encodings
  // ***********************************************
  localparam logic [2:0] GAIN_CODE_8 = 3'h3;
  localparam logic [2:0] RATE_RESERVED = 3'h7;
  localparam logic [1:0] REF_CODE_INTERNAL = 2'h0;
  localparam logic [1:0] REF_CODE_EXTERNAL = 2'h1;
  localparam logic [11:0] MOD_CLK_NORMAL_KHZ = 12'h100;
  localparam logic [11:0] MOD_CLK_TURBO_KHZ = 12'h200;
  localparam logic [7:0] GAIN_UNITY = 8'h01;
  // samples per second per rate code; the reserved code reads as zero
  localparam logic [11:0] RATE_NORMAL_SPS [8] = '{
    12'h014, 12'h02D, 12'h05A, 12'h0AF, 12'h14A, 12'h258, 12'h3E8, 12'h000
  };
  localparam logic [11:0] RATE_TURBO_SPS [8] = '{
    12'h028, 12'h05A, 12'h0B4, 12'h15E, 12'h294, 12'h4B0, 12'h7D0, 12'h000
  };

  typedef enum logic [1:0] {
    ACR_REF_INTERNAL,
    ACR_REF_EXTERNAL,
    ACR_REF_SUPPLY
  } acr_ref_t;
endpackage
`default_nettype wire

/* sim/tb_adc_config_regs.sv */
/*
  Self-checking bench for acr_config_regs: random and corner register
  writes, readback, refused writes and the decoded converter controls.
  Assumes one wait state per Avalon-MM access and a 20 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_adc_config_regs;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, amp_bypass, rate_reserved, temp_sense_enable;
  logic conversion_repeat_select;
  logic [3:0] input_select;
  logic [7:0] input_amplifier_gain, g, r;
  logic [11:0] rate_sps, mod_clk_khz;
  logic [1:0] ref_select;
  logic [41:0] outs, e;
  int fail_count = 0;
  int n_compared = 0;
  int seed = 32'h2fe8c2f9;
  always #25 clk = ~clk;
  acr_config_regs i_dut (.clk(clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .input_select(input_select), .input_amplifier_gain(input_amplifier_gain),
    .amp_bypass(amp_bypass), .rate_sps(rate_sps),
    .rate_reserved(rate_reserved), .mod_clk_khz(mod_clk_khz),
    .conversion_repeat_select(conversion_repeat_select),
    .ref_select(ref_select), .temp_sense_enable(temp_sense_enable));
  // ***********************************************
  // expectation and bus helpers
  // ***********************************************
  function automatic logic [41:0] expect_out(input logic [7:0] gv,
                                             input logic [7:0] rv);
    logic [11:0] tbl [8];
    logic t;
    tbl = '{12'h014, 12'h02D, 12'h05A, 12'h0AF, 12'h14A, 12'h258, 12'h3E8,
            12'h000};
    t = rv[0];
    return {t ? 4'h0 : gv[7:4], t ? 8'h01 : 8'h01 << gv[3:1],
            gv[0] & (gv[3:1] < 3'h3) & ~t, tbl[rv[7:5]] << rv[4],
            rv[7:5] == 3'h7, rv[4] ? 12'h200 : 12'h100, rv[3],
            t ? 2'h0 : (rv[2] ? 2'h2 : rv[2:1]), t};
  endfunction
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // waits for waitrequest low at a rising edge, then releases
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [7:0] d, input logic [3:0] be);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic verify(input logic [7:0] gv, input logic [7:0] rv);
    bus(1'b0, 4'h0, 8'h00, 4'hF);
    check(rd, {24'h000000, gv});
    bus(1'b0, 4'h4, 8'h00, 4'hF);
    check(rd, {24'h000000, rv});
    e = expect_out(gv, rv);
    outs = {input_select, input_amplifier_gain, amp_bypass, rate_sps,
      rate_reserved, mod_clk_khz, conversion_repeat_select, ref_select,
      temp_sense_enable};
    check(outs, e);
    bus(1'b0, 4'h8, 8'h00, 4'hF);
    check(rd, {20'h00000, e[29], e[2:1], e[16], e[37:30]});
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ***********************************************
  // main sequence
  // ***********************************************
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    verify(8'h00, 8'h00);
    // first sixteen pass every rate/turbo code and gain with bypass
    for (int i = 0; i < 64; i++) begin
      g = $random(seed);
      r = $random(seed);
      if (i < 16) begin
        r[7:4] = i[3:0];
        r[0] = 1'b0;
        g[3:0] = {i[2:0], 1'b1};
        g[7] = 1'b0;
      end else if (i < 20) begin
        r[2:0] = {i[1:0], 1'b0};
      end
      // grounded negative input: bypass on, gain one or two only
      if (g[7:6] == 2'b10) begin
        g[3:0] = {2'b00, g[1], 1'b1};
      end
      bus(1'b1, 4'h0, g, 4'hF);
      bus(1'b1, 4'h4, r, 4'hF);
      verify(g, r);
    end
    // lane 0 off and unmapped writes must leave both registers alone
    bus(1'b1, 4'h4, ~r, 4'h0);
    bus(1'b1, 4'hC, ~r, 4'hF);
    verify(g, r);
    bus(1'b0, 4'hC, 8'h00, 4'hF);
    check(rd, 32'h00000000);
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
